// ==== dv/cdb_host_model.sv ====
// Purpose: Two-wire bus master standing in for the host
// Assumes: Open-drain data line resolved with a pull-up in the bench
// Notes:   Every bus phase lasts five core clocks
`timescale 1ns/1ps
`include "cdb_consts.vh"

module cdb_host_model
(
	input  wire clock,
	input  wire sda_line,
	output reg  scl,
	output reg  sda_pull
);
	reg acked = 1'b0;

	initial
	begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end

	task half;
	begin
		repeat (5) @(posedge clock);
		#1;
	end
	endtask

	task put_bit(input b);
	begin
		sda_pull = !b;
		half;
		scl = 1'b1;
		half;
		scl = 1'b0;
		half;
	end
	endtask

	task get_bit(output b);
	begin
		sda_pull = 1'b0;
		half;
		scl = 1'b1;
		half;
		b = sda_line;
		scl = 1'b0;
		half;
	end
	endtask

	task start;
	begin
		sda_pull = 1'b0;
		half;
		scl = 1'b1;
		half;
		sda_pull = 1'b1;
		half;
		scl = 1'b0;
		half;
	end
	endtask

	task stop;
	begin
		sda_pull = 1'b1;
		half;
		scl = 1'b1;
		half;
		sda_pull = 1'b0;
		half;
	end
	endtask

	task wbyte(input [7:0] d);
		integer i;
		reg     a;
	begin
		for (i = 7; i >= 0; i = i - 1)
			put_bit(d[i]);
		get_bit(a);
		acked = !a;
	end
	endtask

	task write_reg(input [7:0] ad, input [7:0] d);
	begin
		start;
		wbyte({`CDB_SLAVE_ADDR, 1'b0});
		wbyte(ad);
		wbyte(d);
		stop;
	end
	endtask

	task read_reg(input [7:0] ad, output [7:0] d);
		integer i;
	begin
		start;
		wbyte({`CDB_SLAVE_ADDR, 1'b0});
		wbyte(ad);
		start;
		wbyte({`CDB_SLAVE_ADDR, 1'b1});
		for (i = 7; i >= 0; i = i - 1)
			get_bit(d[i]);
		put_bit(1'b1);
		stop;
	end
	endtask

	task probe(input [7:0] b);
	begin
		start;
		wbyte(b);
		stop;
	end
	endtask
endmodule // cdb_host_model

// ==== dv/cdb_regs_asserts.sv ====
// Purpose: Port-level checks for the register bank
// Assumes: One clock, asynchronous active-low reset
// Notes:   Bound from the testbench top file
`timescale 1ns/1ps

module cdb_regs_asserts
#(
	parameter DSC_CYCLES = 40
)
(
	input wire       clock,
	input wire       resetn,
	input wire       scl,
	input wire       supply_input,
	input wire       irq_n,
	input wire [1:0] cap_threshold_sel,
	input wire       supply_discharge_pulse,
	input wire       supply_valid,
	input wire [4:0] boost_target_volts
);
	reg [31:0] high_run;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!resetn);

	// Length of the present supply run
	always @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			high_run <= 32'h0;
		else if (!supply_input)
			high_run <= 32'h0;
		else
			high_run <= high_run + 32'h1;
	end

	chk_disc_single: assert property (supply_discharge_pulse |=> !supply_discharge_pulse)
		else $error("discharge pulse wider than one cycle");
	chk_disc_present: assert property (supply_discharge_pulse |-> high_run + 32'h2 >= DSC_CYCLES)
		else $error("discharge without a full present period");
	chk_valid_follow: assert property (supply_input |=> supply_valid)
		else $error("supply valid late after supply present");
	chk_valid_drop: assert property ($fell(supply_valid) |-> !$past(supply_input))
		else $error("supply valid dropped while supply present");
	chk_volts_range: assert property (boost_target_volts >= 5'h06 && boost_target_volts <= 5'h11)
		else $error("boost target outside 6 to 17 volts");
	chk_volts_write: assert property ($changed(boost_target_volts) |-> !scl)
		else $error("boost target changed outside a bus write");
	chk_irq_release: assert property ($rose(irq_n) |-> !scl)
		else $error("interrupt released outside a bus access");
	chk_cap_write: assert property ($changed(cap_threshold_sel) |-> !scl)
		else $error("threshold changed outside a bus write");
endmodule // cdb_regs_asserts

// ==== dv/test_cable_detect_boost_config_regs.sv ====
// Purpose: Self-checking bench for the register bank
// Assumes: Shortened discharge and debounce counts
// Notes:   Registers reached only through the host model
`timescale 1ns/1ps

module test_cable_detect_boost_config_regs;
	localparam [47:0] RST = 48'h0000_05a3_8000;
	localparam [95:0] WR  = 96'h04ff0f_05ffc7_06ff05_20ff00;
	reg        clock = 1'b0, resetn = 1'b0, pin_a = 1'b0, pin_b = 1'b0;
	reg        cable_in = 1'b0, ovp_in = 1'b0, supply_input = 1'b0;
	reg [10:0] ramp = 11'h5a3;
	reg [3:0]  src = 4'h0;
	reg [7:0]  rd;
	wire       scl, sda_pull, sda_oe, irq_n, run, pulse, valid, boost_en;
	wire       sda_line = !(sda_pull | sda_oe);
	wire [1:0] cap;
	wire [4:0] volts;
	integer    failures = 0, comparisons = 0, pulses = 0, i, j;

	always #2.5 clock = !clock;

	always @(posedge clock)
	begin
		if (pulse)
			pulses = pulses + 1;
	end

	cdb_host_model host (.clock(clock), .sda_line(sda_line), .scl(scl), .sda_pull(sda_pull));

	cdb_regs #(.DSC_CYCLES(40), .DEB_STEP_CYCLES(8)) uut
	(
		.clock(clock), .resetn(resetn), .scl(scl), .sda_in(sda_line), .sda_out(),
		.sda_oe(sda_oe), .multipurpose_input_a(pin_a), .multipurpose_input_b(pin_b),
		.cable_detected_in(cable_in), .supply_overvolt_in(ovp_in),
		.supply_input(supply_input), .ramp_shot_count(ramp), .irq_n(irq_n),
		.cable_detect_run(run), .cap_threshold_sel(cap), .supply_discharge_pulse(pulse),
		.supply_valid(valid), .boost_enable(boost_en), .boost_target_volts(volts)
	);

	function sel_on(input [1:0] s, input a, input b);
		sel_on = (s == 2'h1) | (s == 2'h2 & a) | (s == 2'h3 & b);
	endfunction

	task tick(input integer n);
	begin
		repeat (n) @(posedge clock);
		#1;
	end
	endtask

	task check(input [95:0] name, input [7:0] got, input [7:0] exp);
	begin
		comparisons = comparisons + 1;
		if (got !== exp)
		begin
			failures = failures + 1;
			$display("[FAIL] %0s expected %h seen %h", name, exp, got);
		end
	end
	endtask

	task end_sim;
	begin
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	end
	endtask

	initial
	begin
		repeat (60000) @(posedge clock);
		failures = failures + 1;
		end_sim;
	end

	initial
	begin
		tick(4);
		resetn = 1'b1;
		tick(2);
		for (i = 4; i < 10; i = i + 1)
		begin
			host.read_reg(i[7:0], rd);
			check("reset value", rd, RST[8 * (9 - i) +: 8]);
		end
		host.read_reg(8'h03, rd);
		check("status idle", rd, 8'h04);
		$display("test done: reset values");
		for (i = 0; i < 4; i = i + 1)
		begin
			host.write_reg(WR[95 - 24 * i -: 8], WR[87 - 24 * i -: 8]);
			host.read_reg(WR[95 - 24 * i -: 8], rd);
			check("readback", rd, WR[79 - 24 * i -: 8]);
		end
		host.probe(8'h52);
		check("foreign ack", host.acked, 8'h00);
		$display("test done: access kinds");
		for (i = 0; i < 4; i = i + 1)
		begin
			host.write_reg(8'h05, {i[1:0], 4'h1, i[1:0]});
			check("threshold", cap, i[1:0]);
			for (j = 0; j < 4; j = j + 1)
			begin
				pin_a = j[0];
				pin_b = j[1];
				tick(3);
				check("detect run", run, sel_on(i[1:0], j[0], j[1]));
			end
		end
		$display("test done: detect select");
		for (i = 0; i < 16; i = i + 1)
		begin
			host.write_reg(8'h09, {i[1:0], 2'h0, i[3:0]});
			pin_a = i[2];
			pin_b = i[3];
			tick(3);
			check("boost volts", volts, (i < 12) ? i + 6 : 8);
			check("boost enable", boost_en, sel_on(i[1:0], i[2], i[3]));
		end
		$display("test done: boost");
		host.write_reg(8'h05, 8'h04);
		for (i = 0; i < 4; i = i + 1)
		begin
			host.write_reg(8'h04, 8'h0f ^ (8'h01 << i));
			host.read_reg(8'h02, rd);
			src = src ^ (4'h1 << i);
			cable_in = src[3];
			ovp_in = src[1];
			supply_input = src[0];
			host.write_reg(8'h05, {1'b0, src[2], 6'h04});
			tick(4);
			check("masked irq", irq_n, 8'h01);
			host.write_reg(8'h04, 8'h01 << i);
			tick(3);
			check("open irq", irq_n, 8'h00);
			host.read_reg(8'h02, rd);
			check("flag bits", rd, 8'h01 << i);
			tick(3);
			check("cleared irq", irq_n, 8'h01);
		end
		host.read_reg(8'h03, rd);
		check("status run", rd, 8'h0b);
		$display("test done: interrupts");
		host.write_reg(8'h05, 8'h00);
		tick(100);
		pulses = 0;
		tick(400);
		check("pulses on", pulses, 8'd10);
		host.write_reg(8'h05, 8'h04);
		pulses = 0;
		tick(400);
		check("pulses off", pulses, 8'd0);
		host.write_reg(8'h05, 8'h00);
		supply_input = 1'b0;
		tick(2);
		pulses = 0;
		repeat (10)
		begin
			supply_input = 1'b0;
			tick(1);
			supply_input = 1'b1;
			tick(35);
		end
		check("pulses broken", pulses, 8'd0);
		$display("test done: discharge");
		host.write_reg(8'h08, 8'h04);
		supply_input = 1'b0;
		tick(28);
		check("valid held", valid, 8'h01);
		tick(10);
		check("valid dropped", valid, 8'h00);
		$display("test done: debounce");
		end_sim;
	end
endmodule // test_cable_detect_boost_config_regs

bind cdb_regs cdb_regs_asserts #(.DSC_CYCLES(DSC_CYCLES)) chk
(
	.clock(clock), .resetn(resetn), .scl(scl), .supply_input(supply_input),
	.irq_n(irq_n), .cap_threshold_sel(cap_threshold_sel),
	.supply_discharge_pulse(supply_discharge_pulse), .supply_valid(supply_valid),
	.boost_target_volts(boost_target_volts)
);

// ==== logic/cdb_consts.vh ====
// Purpose: Constants for the cable-detect and boost register bank
// Assumes: 200 MHz core clock
// Notes:   Offsets are register addresses on the serial bus
`ifndef CDB_CONSTS_VH
`define CDB_CONSTS_VH

`define CDB_SLAVE_ADDR        7'h28

`define CDB_REG_IRQ_FLAGS     8'h02
`define CDB_REG_STATUS        8'h03
`define CDB_REG_IRQ_MASK      8'h04
`define CDB_REG_CABLE_DETECT_CONFIG        8'h05
`define CDB_REG_RAMP_HIGH     8'h06
`define CDB_REG_RAMP_LOW      8'h07
`define CDB_REG_DEBOUNCE      8'h08
`define CDB_REG_BOOST_CFG     8'h09

`define CDB_RST_IRQ_MASK      4'h0
`define CDB_RST_CABLE_DETECT_ENABLE_SEL         2'h0
`define CDB_RST_DSC_DIS       1'b0
`define CDB_RST_CTH           2'h0
`define CDB_RST_DEBOUNCE      8'h80
`define CDB_RST_BOOST_EN      2'h0
`define CDB_RST_BOOST_V       4'h0

`define CDB_F_CABLE_DETECT_ENABLE_SEL_HI        7
`define CDB_F_CABLE_DETECT_ENABLE_SEL_LO        6
`define CDB_F_DSC_DIS         2
`define CDB_F_CTH_HI          1
`define CDB_F_CTH_LO          0
`define CDB_F_BOOST_ENABLE_SEL_HI       7
`define CDB_F_BOOST_ENABLE_SEL_LO       6
`define CDB_F_BOOST_VOLTAGE_CODE_HI        3
`define CDB_F_BOOST_VOLTAGE_CODE_LO        0

`define CDB_SEL_OFF           2'h0
`define CDB_SEL_ON            2'h1
`define CDB_SEL_PIN_A         2'h2
`define CDB_SEL_PIN_B         2'h3

`define CDB_BOOST_VOLTAGE_CODE_MAX_CODE    4'hb
`define CDB_BOOST_VOLTAGE_CODE_BASE        5'h06
`define CDB_BOOST_VOLTAGE_CODE_ALT         5'h08

`define CDB_CLK_PERIOD_NS     5
`define CDB_DSC_PERIOD_NS     250000000
`define CDB_DEB_STEP_NS       500000
`define CDB_DSC_CYCLES        (`CDB_DSC_PERIOD_NS / `CDB_CLK_PERIOD_NS)
`define CDB_DEB_STEP_CYCLES   (`CDB_DEB_STEP_NS / `CDB_CLK_PERIOD_NS)

`endif

// ==== logic/cdb_i2c_slave.v ====
// Purpose: Serial two-wire slave, byte engine with register pointer
// Assumes: scl and sda_in synchronous to clock, slow against it
// Notes:   Pointer auto-increments after each data byte
`timescale 1ns/1ps
`include "cdb_consts.vh"

module cdb_i2c_slave
(
	input  wire       clock,
	input  wire       resetn,
	input  wire       scl,
	input  wire       sda_in,
	output reg        sda_oe,
	output reg        wr_en,
	output reg  [7:0] wr_addr,
	output reg  [7:0] wr_data,
	output reg        rd_en,
	output wire [7:0] rd_addr,
	input  wire [7:0] rd_data
);

	localparam [2:0] ST_IDLE  = 3'd0;
	localparam [2:0] ST_ADDR  = 3'd1;
	localparam [2:0] ST_ACKA  = 3'd2;
	localparam [2:0] ST_WPTR  = 3'd3;
	localparam [2:0] ST_WDATA = 3'd4;
	localparam [2:0] ST_ACKW  = 3'd5;
	localparam [2:0] ST_RLOAD = 3'd6;
	localparam [2:0] ST_RDATA = 3'd7;

	reg  [2:0] state;
	reg  [3:0] bit_cnt;
	reg  [7:0] shift;
	reg  [7:0] ptr;
	reg        scl_q;
	reg        sda_q;
	reg        is_read;
	reg        in_rack;
	reg        master_ack;
	wire       scl_rise;
	wire       scl_fall;
	wire       start_cond;
	wire       stop_cond;

	assign rd_addr    = ptr;
	assign scl_rise   = scl & ~scl_q;
	assign scl_fall   = ~scl & scl_q;
	assign start_cond = scl & scl_q & sda_q & ~sda_in;
	assign stop_cond  = scl & scl_q & ~sda_q & sda_in;

	always @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			state      <= ST_IDLE;
			bit_cnt    <= 4'h0;
			shift      <= 8'h00;
			ptr        <= 8'h00;
			scl_q      <= 1'b1;
			sda_q      <= 1'b1;
			is_read    <= 1'b0;
			in_rack    <= 1'b0;
			master_ack <= 1'b0;
			sda_oe     <= 1'b0;
			wr_en      <= 1'b0;
			wr_addr    <= 8'h00;
			wr_data    <= 8'h00;
			rd_en      <= 1'b0;
		end
		else
		begin
			scl_q <= scl;
			sda_q <= sda_in;
			wr_en <= 1'b0;
			rd_en <= 1'b0;
			if (start_cond)
			begin
				state   <= ST_ADDR;
				bit_cnt <= 4'h0;
				sda_oe  <= 1'b0;
			end
			else if (stop_cond)
			begin
				state  <= ST_IDLE;
				sda_oe <= 1'b0;
			end
			else
			begin
				case (state)
					ST_ADDR, ST_WPTR, ST_WDATA:
					begin
						if (scl_rise)
						begin
							shift   <= {shift[6:0], sda_in};
							bit_cnt <= bit_cnt + 4'h1;
						end
						else if (scl_fall && bit_cnt == 4'h8)
						begin
							if (state == ST_ADDR)
							begin
								if (shift[7:1] == `CDB_SLAVE_ADDR)
								begin
									sda_oe  <= 1'b1;
									is_read <= shift[0];
									state   <= ST_ACKA;
								end
								else
									state <= ST_IDLE;
							end
							else
							begin
								sda_oe <= 1'b1;
								state  <= ST_ACKW;
								if (state == ST_WPTR)
									ptr <= shift;
								else
								begin
									wr_en   <= 1'b1;
									wr_addr <= ptr;
									wr_data <= shift;
									ptr     <= ptr + 8'h01;
								end
							end
						end
					end
					ST_ACKA:
					begin
						if (scl_fall)
						begin
							sda_oe  <= 1'b0;
							bit_cnt <= 4'h0;
							if (is_read)
							begin
								rd_en <= 1'b1;
								state <= ST_RLOAD;
							end
							else
								state <= ST_WPTR;
						end
					end
					ST_ACKW:
					begin
						if (scl_fall)
						begin
							sda_oe  <= 1'b0;
							bit_cnt <= 4'h0;
							state   <= ST_WDATA;
						end
					end
					ST_RLOAD:
					begin
						shift   <= rd_data;
						sda_oe  <= ~rd_data[7];
						ptr     <= ptr + 8'h01;
						bit_cnt <= 4'h0;
						in_rack <= 1'b0;
						state   <= ST_RDATA;
					end
					ST_RDATA:
					begin
						if (in_rack)
						begin
							if (scl_rise)
								master_ack <= ~sda_in;
							else if (scl_fall)
							begin
								if (master_ack)
								begin
									rd_en <= 1'b1;
									state <= ST_RLOAD;
								end
								else
									state <= ST_IDLE;
							end
						end
						else if (scl_fall)
						begin
							if (bit_cnt == 4'h7)
							begin
								sda_oe  <= 1'b0;
								in_rack <= 1'b1;
							end
							else
							begin
								shift   <= {shift[6:0], 1'b0};
								sda_oe  <= ~shift[6];
								bit_cnt <= bit_cnt + 4'h1;
							end
						end
					end
					default:
						state <= ST_IDLE;
				endcase
			end
		end
	end

endmodule // cdb_i2c_slave

// ==== logic/cdb_regs.v ====
// Purpose: Cable-detect, supply and boost configuration register bank
// Assumes: All inputs synchronous to clock; analog results arrive as levels
// Notes:   Registers reached over the two-wire serial slave only
`timescale 1ns/1ps
`include "cdb_consts.vh"

// Overview of operation
// RULE_01 - Mask bit 3 passes cable-change flag to interrupt pin when 1
// RULE_02 - Mask bit 2 passes detect-busy-change flag to interrupt pin when 1
// RULE_03 - Mask bit 1 passes overvoltage-change flag to interrupt pin when 1
// RULE_04 - Mask bit 0 passes supply-present-change flag to interrupt pin when 1
// RULE_05 - Detect select 00 off, 01 on, pins ignored
// RULE_06 - Detect select 10 follows input A, 11 follows input B
// RULE_07 - Discharge supply every 250 ms if present throughout, unless disabled
// RULE_08 - Threshold select 00..11 gives 20, 40, 60, 80 pF
// RULE_09 - Eleven-bit ramp count, bits 10:8 high register, 7:0 low
// RULE_10 - Falling supply debounced for count times 0.5 ms before invalid
// RULE_11 - Debounce count resets to 128, about 64 ms
// RULE_12 - Boost select 00 off, 01 on, 10 input A, 11 input B
// RULE_13 - Voltage code 0..11 gives 6..17 V, codes 12..15 give 8 V
// RULE_14 - Flags set on status change, all cleared by reading flag register
// RULE_15 - Busy status reads 0 while detection runs, 1 otherwise
module cdb_regs
#(
	parameter DSC_CYCLES      = `CDB_DSC_CYCLES,
	parameter DEB_STEP_CYCLES = `CDB_DEB_STEP_CYCLES
)
(
	input  wire        clock,
	input  wire        resetn,
	input  wire        scl,
	input  wire        sda_in,
	output wire        sda_out,
	output wire        sda_oe,
	input  wire        multipurpose_input_a,
	input  wire        multipurpose_input_b,
	input  wire        cable_detected_in,
	input  wire        supply_overvolt_in,
	input  wire        supply_input,
	input  wire [10:0] ramp_shot_count,
	output reg         irq_n,
	output reg         cable_detect_run,
	output reg  [1:0]  cap_threshold_sel,
	output reg         supply_discharge_pulse,
	output reg         supply_valid,
	output reg         boost_enable,
	output reg  [4:0]  boost_target_volts
);

	reg  [3:0]  irq_enable_mask;
	reg  [1:0]  cable_detect_enable_sel;
	reg         supply_discharge_disable;
	reg  [7:0]  supply_fall_debounce_count;
	reg  [1:0]  boost_enable_sel;
	reg  [3:0]  boost_voltage_code;
	reg  [3:0]  irq_flags;
	reg  [3:0]  status;
	reg  [10:0] ramp_count;
	reg  [31:0] dsc_timer;
	reg  [31:0] deb_timer;
	reg  [7:0]  deb_steps;
	reg  [7:0]  rd_data;
	reg  [3:0]  next_flags;
	wire [3:0]  next_status;
	wire        wr_en;
	wire [7:0]  wr_addr;
	wire [7:0]  wr_data;
	wire        rd_en;
	wire [7:0]  rd_addr;

	// Four-way enable selector shared by detection and boost
	function sel_active;
		input [1:0] sel;
		input       pin_a;
		input       pin_b;
		begin
			case (sel)
				`CDB_SEL_OFF:   sel_active = 1'b0;
				`CDB_SEL_ON:    sel_active = 1'b1;
				`CDB_SEL_PIN_A: sel_active = pin_a;
				default:        sel_active = pin_b;
			endcase
		end
	endfunction

	assign sda_out = 1'b0;

	cdb_i2c_slave u_slave
	(
		.clock   (clock),
		.resetn  (resetn),
		.scl     (scl),
		.sda_in  (sda_in),
		.sda_oe  (sda_oe),
		.wr_en   (wr_en),
		.wr_addr (wr_addr),
		.wr_data (wr_data),
		.rd_en   (rd_en),
		.rd_addr (rd_addr),
		.rd_data (rd_data)
	);

	// RULE_15 busy is inverse of run
	assign next_status = {cable_detected_in, ~cable_detect_run,
		supply_overvolt_in, supply_input};

	// Register read view
	always @*
	begin
		case (rd_addr)
			`CDB_REG_IRQ_FLAGS: rd_data = {4'h0, irq_flags};
			`CDB_REG_STATUS:    rd_data = {4'h0, status};
			`CDB_REG_IRQ_MASK:  rd_data = {4'h0, irq_enable_mask};
			`CDB_REG_CABLE_DETECT_CONFIG:    rd_data = {cable_detect_enable_sel, 3'h0,
				supply_discharge_disable, cap_threshold_sel};
			// RULE_09 ramp count split
			`CDB_REG_RAMP_HIGH: rd_data = {5'h00, ramp_count[10:8]};
			`CDB_REG_RAMP_LOW:  rd_data = ramp_count[7:0];
			`CDB_REG_DEBOUNCE:  rd_data = supply_fall_debounce_count;
			`CDB_REG_BOOST_CFG: rd_data = {boost_enable_sel, 2'h0, boost_voltage_code};
			default:            rd_data = 8'h00;
		endcase
	end

	// RULE_14 change sets, set wins over read clear
	always @*
	begin
		next_flags = irq_flags;
		if (rd_en && rd_addr == `CDB_REG_IRQ_FLAGS)
			next_flags = 4'h0;
		next_flags = next_flags | (status ^ next_status);
	end

	// Software-written configuration
	always @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			irq_enable_mask            <= `CDB_RST_IRQ_MASK;
			cable_detect_enable_sel    <= `CDB_RST_CABLE_DETECT_ENABLE_SEL;
			supply_discharge_disable   <= `CDB_RST_DSC_DIS;
			cap_threshold_sel          <= `CDB_RST_CTH;
			// RULE_11 default debounce
			supply_fall_debounce_count <= `CDB_RST_DEBOUNCE;
			boost_enable_sel           <= `CDB_RST_BOOST_EN;
			boost_voltage_code         <= `CDB_RST_BOOST_V;
		end
		else if (wr_en)
		begin
			case (wr_addr)
				`CDB_REG_IRQ_MASK:
					irq_enable_mask <= wr_data[3:0];
				`CDB_REG_CABLE_DETECT_CONFIG:
				begin
					cable_detect_enable_sel  <= wr_data[`CDB_F_CABLE_DETECT_ENABLE_SEL_HI:`CDB_F_CABLE_DETECT_ENABLE_SEL_LO];
					supply_discharge_disable <= wr_data[`CDB_F_DSC_DIS];
					// RULE_08 threshold code drive
					cap_threshold_sel        <= wr_data[`CDB_F_CTH_HI:`CDB_F_CTH_LO];
				end
				`CDB_REG_DEBOUNCE:
					supply_fall_debounce_count <= wr_data;
				`CDB_REG_BOOST_CFG:
				begin
					boost_enable_sel   <= wr_data[`CDB_F_BOOST_ENABLE_SEL_HI:`CDB_F_BOOST_ENABLE_SEL_LO];
					boost_voltage_code <= wr_data[`CDB_F_BOOST_VOLTAGE_CODE_HI:`CDB_F_BOOST_VOLTAGE_CODE_LO];
				end
				default:
					irq_enable_mask <= irq_enable_mask;
			endcase
		end
	end

	// Status, flags, interrupt and control outputs
	always @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			status             <= 4'h0;
			irq_flags          <= 4'h0;
			ramp_count         <= 11'h000;
			irq_n              <= 1'b1;
			cable_detect_run   <= 1'b0;
			boost_enable       <= 1'b0;
			boost_target_volts <= `CDB_BOOST_VOLTAGE_CODE_BASE;
		end
		else
		begin
			status     <= next_status;
			irq_flags  <= next_flags;
			ramp_count <= ramp_shot_count;
			// RULE_01 RULE_02 RULE_03 RULE_04 mask gating
			irq_n <= ~|(irq_flags & irq_enable_mask);
			// RULE_05 RULE_06 detection select
			cable_detect_run <= sel_active(cable_detect_enable_sel,
				multipurpose_input_a, multipurpose_input_b);
			// RULE_12 boost select
			boost_enable <= sel_active(boost_enable_sel,
				multipurpose_input_a, multipurpose_input_b);
			// RULE_13 voltage decode
			if (boost_voltage_code > `CDB_BOOST_VOLTAGE_CODE_MAX_CODE)
				boost_target_volts <= `CDB_BOOST_VOLTAGE_CODE_ALT;
			else
				boost_target_volts <= `CDB_BOOST_VOLTAGE_CODE_BASE + {1'b0, boost_voltage_code};
		end
	end

	// RULE_07 periodic discharge timer
	always @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			dsc_timer              <= 32'h0;
			supply_discharge_pulse <= 1'b0;
		end
		else
		begin
			supply_discharge_pulse <= 1'b0;
			if (!supply_input)
				dsc_timer <= 32'h0;
			else if (dsc_timer >= DSC_CYCLES - 1)
			begin
				dsc_timer              <= 32'h0;
				supply_discharge_pulse <= ~supply_discharge_disable;
			end
			else
				dsc_timer <= dsc_timer + 32'h1;
		end
	end

	// RULE_10 falling supply debounce
	always @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			deb_timer    <= 32'h0;
			deb_steps    <= 8'h00;
			supply_valid <= 1'b0;
		end
		else if (supply_input)
		begin
			deb_timer    <= 32'h0;
			deb_steps    <= 8'h00;
			supply_valid <= 1'b1;
		end
		else if (supply_valid)
		begin
			if (deb_steps >= supply_fall_debounce_count)
				supply_valid <= 1'b0;
			else if (deb_timer >= DEB_STEP_CYCLES - 1)
			begin
				deb_timer <= 32'h0;
				deb_steps <= deb_steps + 8'h01;
			end
			else
				deb_timer <= deb_timer + 32'h1;
		end
	end

endmodule // cdb_regs
